// *** logic/parity_defines.svh ***
/*
  Constants for the port parity check and generate block: bus widths, byte layout,
  buffer depth and reset values. Assumes it is included by bare name before use.
*/
`ifndef PARITY_DEFINES_SVH
`define PARITY_DEFINES_SVH

`define PAR_BUS_W 36
`define PAR_BYTE_W 9
`define PAR_BYTE_DATA_W 8
`define PAR_BYTES 4
`define PAR_FIFO_DEPTH 4
`define PAR_BUS_RESET 36'h0_0000_0000

`endif

// *** logic/parity_pkg.sv ***
/*
  Types shared by the port parity block: the per-port control group and the decoded
  kind of access. Assumes parity_defines.svh sits beside it.
*/
`include "parity_defines.svh"

package parity_pkg;

  typedef logic [`PAR_BUS_W-1:0] bus_word_t;

  typedef struct packed {
    logic chip_select_n;
    logic access_strobe;
    logic direction;
    logic mailbox_pick;
    logic parity_gen_select;
  } port_ctrl_t;

  typedef enum logic [4:0] {
    ACC_NONE = 5'h01,
    ACC_FIFO_WR = 5'h02,
    ACC_FIFO_RD = 5'h04,
    ACC_BOX_WR = 5'h08,
    ACC_BOX_RD = 5'h10
  } access_t;

endpackage

// *** logic/port_parity_check_generate.sv ***
/*
  Port parity checking and generation for a two-port word buffer with two mailboxes,
  plus the small word FIFO that carries data from port A to port B.
  Assumes both ports are driven synchronously to i_sys_clk and that the testbench
  resolves each bidirectional bus from the matching output enable.
*/
// Function
// - Four parity trees per port check the input bus and drive a low-active fault flag.
// - Each 36-bit word splits into bytes at bits 0-8, 9-17, 18-26, 27-35.
// - Odd sense faults on odd count of low bits; even sense on even count.
// - One shared sense input governs checking on both ports.
// - Port A trees generate parity for box B-to-A; port B trees for box A-to-B.
// - Port A mailbox read with generation forces port A fault flag high.
// - Port B mailbox read with generation forces port B fault flag high.
// - High generate select makes parity for that port's mailbox reads, and for port B FIFO reads.
// - Writes store all 36 bits unchanged whatever the generate selects are.
// - Parity comes from each byte's low eight bits and the sense setting.
// - Generated parity replaces each byte's top bit only on the data outputs.
// - Generating parity for a mailbox read leaves the mailbox contents untouched.
// - FIFO parity is made before the port B output register, sampled at its edge.
// - Mailbox generation needs direction low, pick high, select low, strobe high, generate high.
// - Port B outputs show the FIFO register with pick low, box A-to-B with pick high.
// - Port A outputs always show the box B-to-A contents.

module word_fifo #(
  parameter int WIDTH = `PAR_BUS_W,
  parameter int DEPTH = `PAR_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic push;
  logic pop;

  assign o_in_ready = (count_r != CNT_W'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Storage has no reset: count_r alone says which words are valid, so old contents never leak out.
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule

module port_parity_check_generate #(
  parameter int FIFO_DEPTH = `PAR_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_parity_odd,
  input wire parity_pkg::port_ctrl_t i_port_a_ctrl,
  input wire parity_pkg::bus_word_t i_port_a_bus,
  output parity_pkg::bus_word_t o_port_a_bus,
  output logic o_port_a_oe,
  output logic o_port_a_parity_fault_n,
  output logic o_port_a_fifo_ready,
  input wire parity_pkg::port_ctrl_t i_port_b_ctrl,
  input wire parity_pkg::bus_word_t i_port_b_bus,
  output parity_pkg::bus_word_t o_port_b_bus,
  output logic o_port_b_oe,
  output logic o_port_b_parity_fault_n,
  output logic o_port_b_fifo_valid
);
  parity_pkg::access_t acc_a;
  parity_pkg::access_t acc_b;
  parity_pkg::bus_word_t box_a_to_b_r;
  parity_pkg::bus_word_t box_b_to_a_r;
  parity_pkg::bus_word_t fifo_out_r;
  parity_pkg::bus_word_t fifo_head;
  logic gen_box_a;
  logic gen_box_b;
  logic fifo_rd_b;
  logic fifo_pop;

  // Byte lanes sit at bit 0, 9, 18 and 27; the top bit of each lane is parity.
  function automatic logic [`PAR_BYTES-1:0] byte_faults(input parity_pkg::bus_word_t w, input logic odd);
    logic [`PAR_BYTES-1:0] f;
    f = '0;
    for (int i = 0; i < `PAR_BYTES; i++) begin
      // Odd sense wants an odd count of ones in nine bits, i.e. an even count of lows.
      f[i] = odd ? !(^w[i*`PAR_BYTE_W +: `PAR_BYTE_W]) : (^w[i*`PAR_BYTE_W +: `PAR_BYTE_W]);
    end
    return f;
  endfunction

  function automatic parity_pkg::bus_word_t gen_parity(input parity_pkg::bus_word_t w, input logic odd,
                                                       input logic en);
    parity_pkg::bus_word_t r;
    r = w;
    for (int i = 0; i < `PAR_BYTES; i++) begin
      if (en) begin
        r[i*`PAR_BYTE_W + `PAR_BYTE_DATA_W] = odd ? !(^w[i*`PAR_BYTE_W +: `PAR_BYTE_DATA_W])
                                                  : (^w[i*`PAR_BYTE_W +: `PAR_BYTE_DATA_W]);
      end
    end
    return r;
  endfunction

  function automatic parity_pkg::access_t decode(input parity_pkg::port_ctrl_t c);
    parity_pkg::access_t k;
    k = parity_pkg::ACC_NONE;
    if (!c.chip_select_n && c.access_strobe) begin
      unique case ({c.direction, c.mailbox_pick})
        2'b10: k = parity_pkg::ACC_FIFO_WR;
        2'b00: k = parity_pkg::ACC_FIFO_RD;
        2'b11: k = parity_pkg::ACC_BOX_WR;
        2'b01: k = parity_pkg::ACC_BOX_RD;
      endcase
    end
    return k;
  endfunction

  assign acc_a = decode(i_port_a_ctrl);
  assign acc_b = decode(i_port_b_ctrl);

  assign gen_box_a = (acc_a == parity_pkg::ACC_BOX_RD) && i_port_a_ctrl.parity_gen_select;
  assign gen_box_b = (acc_b == parity_pkg::ACC_BOX_RD) && i_port_b_ctrl.parity_gen_select;

  // The trees are shared: while they generate for a mailbox the bus is not checked.
  assign o_port_a_parity_fault_n = gen_box_a || !(|byte_faults(i_port_a_bus, i_parity_odd));
  assign o_port_b_parity_fault_n = gen_box_b || !(|byte_faults(i_port_b_bus, i_parity_odd));

  // The strobe is left out of the enable so the bus stays driven between back-to-back reads.
  assign o_port_a_oe = !i_port_a_ctrl.chip_select_n && !i_port_a_ctrl.direction;
  assign o_port_b_oe = !i_port_b_ctrl.chip_select_n && !i_port_b_ctrl.direction;

  // Mailbox parity is substituted on the way out, so the stored word is never rewritten.
  assign o_port_a_bus = gen_parity(box_b_to_a_r, i_parity_odd, gen_box_a);
  assign o_port_b_bus = i_port_b_ctrl.mailbox_pick ? gen_parity(box_a_to_b_r, i_parity_odd, gen_box_b)
                                                   : fifo_out_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      box_a_to_b_r <= `PAR_BUS_RESET;
    end else if (acc_a == parity_pkg::ACC_BOX_WR) begin
      box_a_to_b_r <= i_port_a_bus;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      box_b_to_a_r <= `PAR_BUS_RESET;
    end else if (acc_b == parity_pkg::ACC_BOX_WR) begin
      box_b_to_a_r <= i_port_b_bus;
    end
  end

  assign fifo_rd_b = (acc_b == parity_pkg::ACC_FIFO_RD);
  assign fifo_pop = fifo_rd_b && o_port_b_fifo_valid;

  // A port A write is refused while the buffer is full; o_port_a_fifo_ready tells the writer.
  word_fifo #(
    .WIDTH(`PAR_BUS_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(acc_a == parity_pkg::ACC_FIFO_WR),
    .o_in_ready(o_port_a_fifo_ready),
    .i_in_data(i_port_a_bus),
    .o_out_valid(o_port_b_fifo_valid),
    .i_out_ready(fifo_rd_b),
    .o_out_data(fifo_head)
  );

  // Generate select and sense are sampled by the edge that loads the output register.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fifo_out_r <= `PAR_BUS_RESET;
    end else if (fifo_pop) begin
      fifo_out_r <= gen_parity(fifo_head, i_parity_odd, i_port_b_ctrl.parity_gen_select);
    end
  end

  // Flags are checked against an independent byte count, not against byte_faults itself.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  property p_fault_a_forced;
    gen_box_a |-> o_port_a_parity_fault_n;
  endproperty
  a_fault_a_forced: assert property (p_fault_a_forced) else $error("port A flag low in generating read");

  property p_fault_b_forced;
    (acc_b == parity_pkg::ACC_BOX_RD && i_port_b_ctrl.parity_gen_select) |-> o_port_b_parity_fault_n;
  endproperty
  a_fault_b_forced: assert property (p_fault_b_forced) else $error("port B flag low in generating read");

  property p_check_a;
    !gen_box_a && i_parity_odd && ($countones(~i_port_a_bus[8:0]) % 2 == 1) |-> !o_port_a_parity_fault_n;
  endproperty
  a_check_a: assert property (p_check_a) else $error("port A odd-low byte not flagged");

  property p_check_b_even;
    !gen_box_b && !i_parity_odd && ($countones(~i_port_b_bus[35:27]) % 2 == 0) |-> !o_port_b_parity_fault_n;
  endproperty
  a_check_b_even: assert property (p_check_b_even) else $error("port B even-low byte not flagged");

  property p_fifo_gen;
    fifo_pop && i_port_b_ctrl.parity_gen_select |=>
      ($countones(fifo_out_r[17:9]) % 2 == 1) == $past(i_parity_odd);
  endproperty
  a_fifo_gen: assert property (p_fifo_gen) else $error("FIFO word parity wrong after load");

  property p_box_store;
    acc_a == parity_pkg::ACC_BOX_WR |=> box_a_to_b_r == $past(i_port_a_bus);
  endproperty
  a_box_store: assert property (p_box_store) else $error("mailbox did not store raw word");

  property p_box_kept;
    gen_box_b && acc_a != parity_pkg::ACC_BOX_WR |=> $stable(box_a_to_b_r);
  endproperty
  a_box_kept: assert property (p_box_kept) else $error("mailbox changed by generating read");

  property p_a_source;
    o_port_a_oe |-> o_port_a_bus[34:27] == box_b_to_a_r[34:27] &&
      (gen_box_a || o_port_a_bus == box_b_to_a_r);
  endproperty
  a_a_source: assert property (p_a_source) else $error("port A output not from mailbox");

  property p_b_source;
    o_port_b_oe && !i_port_b_ctrl.mailbox_pick |-> o_port_b_bus == fifo_out_r;
  endproperty
  a_b_source: assert property (p_b_source) else $error("port B output not from FIFO register");

  property p_gen_top;
    gen_box_a |-> ($countones(o_port_a_bus[26:18]) % 2 == 1) == i_parity_odd;
  endproperty
  a_gen_top: assert property (p_gen_top) else $error("port A generated parity wrong");

  property p_flag_a_full;
    !gen_box_a |-> o_port_a_parity_fault_n == (
      (($countones(i_port_a_bus[8:0]) % 2 == 1) == i_parity_odd) &&
      (($countones(i_port_a_bus[17:9]) % 2 == 1) == i_parity_odd) &&
      (($countones(i_port_a_bus[26:18]) % 2 == 1) == i_parity_odd) &&
      (($countones(i_port_a_bus[35:27]) % 2 == 1) == i_parity_odd));
  endproperty
  a_flag_a_full: assert property (p_flag_a_full) else $error("port A flag disagrees with bytes");

  property p_flag_b_full;
    !gen_box_b |-> o_port_b_parity_fault_n == (
      (($countones(i_port_b_bus[8:0]) % 2 == 1) == i_parity_odd) &&
      (($countones(i_port_b_bus[17:9]) % 2 == 1) == i_parity_odd) &&
      (($countones(i_port_b_bus[26:18]) % 2 == 1) == i_parity_odd) &&
      (($countones(i_port_b_bus[35:27]) % 2 == 1) == i_parity_odd));
  endproperty
  a_flag_b_full: assert property (p_flag_b_full) else $error("port B flag disagrees with bytes");

  property p_box_b_store;
    acc_b == parity_pkg::ACC_BOX_WR |=> box_b_to_a_r == $past(i_port_b_bus);
  endproperty
  a_box_b_store: assert property (p_box_b_store) else $error("B-to-A mailbox did not store raw word");

  property p_box_a_kept;
    gen_box_a && acc_b != parity_pkg::ACC_BOX_WR |=> $stable(box_b_to_a_r);
  endproperty
  a_box_a_kept: assert property (p_box_a_kept) else $error("B-to-A mailbox changed by generating read");

  property p_box_a_idle;
    acc_a != parity_pkg::ACC_BOX_WR |=> $stable(box_a_to_b_r);
  endproperty
  a_box_a_idle: assert property (p_box_a_idle) else $error("A-to-B mailbox changed without a write");

  property p_gen_b;
    gen_box_b |-> (($countones(o_port_b_bus[8:0]) % 2 == 1) == i_parity_odd) &&
      o_port_b_bus[34:27] == box_a_to_b_r[34:27];
  endproperty
  a_gen_b: assert property (p_gen_b) else $error("port B generated mailbox word wrong");

  property p_gen_a_low;
    gen_box_a |-> o_port_a_bus[7:0] == box_b_to_a_r[7:0] &&
      o_port_a_bus[16:9] == box_b_to_a_r[16:9];
  endproperty
  a_gen_a_low: assert property (p_gen_a_low) else $error("port A generation touched data bits");

  property p_fifo_raw;
    fifo_pop && !i_port_b_ctrl.parity_gen_select |=> fifo_out_r == $past(fifo_head);
  endproperty
  a_fifo_raw: assert property (p_fifo_raw) else $error("FIFO word altered without generation");

  property p_fifo_hold;
    !fifo_pop |=> $stable(fifo_out_r);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("FIFO output register changed without a read");

  property p_b_box_source;
    o_port_b_oe && i_port_b_ctrl.mailbox_pick && !gen_box_b |-> o_port_b_bus == box_a_to_b_r;
  endproperty
  a_b_box_source: assert property (p_b_box_source) else $error("port B output not from mailbox");

  c_fifo_refused: cover property (!o_port_a_fifo_ready && acc_a == parity_pkg::ACC_FIFO_WR);
  c_fifo_gen: cover property (fifo_pop && i_port_b_ctrl.parity_gen_select);
  c_box_gen_b: cover property (gen_box_b ##1 gen_box_b);
  c_fault_a: cover property (!o_port_a_parity_fault_n ##1 o_port_a_parity_fault_n);
  c_fifo_full: cover property (!o_port_a_fifo_ready);
endmodule

// *** tb/port_host.sv ***
/*
  Model of the processor that sits on one port: it resolves the shared bus.
  Assumes the device drives only while its output enable is high.
*/
module port_host (
  input wire logic i_sys_clk,
  input wire logic i_host_oe,
  input wire parity_pkg::bus_word_t i_host_word,
  input wire logic i_dev_oe,
  input wire parity_pkg::bus_word_t i_dev_word,
  output parity_pkg::bus_word_t o_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  parity_pkg::bus_word_t last_r = 36'h0_0000_0000;
  always @(posedge i_sys_clk) begin
    last_r <= o_wire;
  end
  // A released bus shows the inverse of its last level so stale data never matches.
  always_comb begin
    if (i_dev_oe) begin
      o_wire = i_dev_word;
    end else if (i_host_oe) begin
      o_wire = i_host_word;
    end else begin
      o_wire = ~last_r;
    end
  end
endmodule

// *** tb/port_parity_check_generate_bench.sv ***
/*
  Self-checking bench for the port parity block: checking, mailbox and FIFO generation.
  Assumes both ports share i_sys_clk and a processor model resolves each bus.
*/
module port_parity_check_generate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_parity_odd = 1'b0;
  parity_pkg::port_ctrl_t ctrl [2];
  parity_pkg::bus_word_t drv [2];
  parity_pkg::bus_word_t bus_w [2];
  parity_pkg::bus_word_t dout [2];
  parity_pkg::bus_word_t w [5];
  parity_pkg::bus_word_t exp_q [6];
  logic oe [2];
  logic fault_n [2];
  logic fifo_ready;
  logic fifo_valid;
  logic gen;
  int miscompares = 0;
  int n_tests = 0;

  port_parity_check_generate #(.FIFO_DEPTH(4)) dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_parity_odd(i_parity_odd), .i_port_a_ctrl(ctrl[0]), .i_port_a_bus(bus_w[0]), .o_port_a_bus(dout[0]),
    .o_port_a_oe(oe[0]), .o_port_a_parity_fault_n(fault_n[0]), .o_port_a_fifo_ready(fifo_ready),
    .i_port_b_ctrl(ctrl[1]), .i_port_b_bus(bus_w[1]), .o_port_b_bus(dout[1]), .o_port_b_oe(oe[1]),
    .o_port_b_parity_fault_n(fault_n[1]), .o_port_b_fifo_valid(fifo_valid));
  for (genvar p = 0; p < 2; p++) begin : g_host
    port_host host_u (.i_sys_clk(i_sys_clk), .i_host_oe(1'b1), .i_host_word(drv[p]), .i_dev_oe(oe[p]),
      .i_dev_word(dout[p]), .o_wire(bus_w[p]));
  end

  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  function automatic parity_pkg::bus_word_t gen_word(parity_pkg::bus_word_t v, logic odd);
    gen_word = v;
    for (int i = 0; i < 4; i++) begin
      gen_word[9*i+8] = (^v[9*i +: 8]) ^ odd;
    end
  endfunction

  function automatic logic fault_exp(parity_pkg::bus_word_t v, logic odd);
    fault_exp = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if ((^v[9*i +: 9]) != odd) begin
        fault_exp = 1'b0;
      end
    end
  endfunction

  function automatic parity_pkg::bus_word_t rnd_word();
    rnd_word = 36'({$urandom, $urandom});
  endfunction

  task automatic check(string name, logic [35:0] seen, logic [35:0] expv);
    n_tests++;
    if (seen !== expv) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic put(int p, logic [4:0] c, parity_pkg::bus_word_t v);
    @(negedge i_sys_clk);
    ctrl[p] = c;
    drv[p] = v;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    ctrl[0] = 5'h10;
    ctrl[1] = 5'h10;
    drv[0] = 36'h0_0000_0000;
    drv[1] = 36'h0_0000_0000;
    void'($urandom(69040));
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_reset = 1'b0;
    check("fifo_ready", fifo_ready, 1'b1);
    check("fifo_valid", fifo_valid, 1'b0);
    // Idle ports: flags follow bus and sense levels within the cycle, all-zero and all-one port A words first.
    for (int i = 0; i < 40; i++) begin
      put(0, 5'h10, (i < 2) ? {36{i[0]}} : rnd_word());
      drv[1] = rnd_word();
      i_parity_odd = (i < 4) ? i[1] : 1'($urandom);
      #1;
      for (int p = 0; p < 2; p++) begin
        check("fault_n", fault_n[p], fault_exp(drv[p], i_parity_odd));
      end
    end
    // Mailbox: write from the far port, read with generation on and then off.
    for (int p = 0; p < 2; p++) begin
      w[0] = rnd_word();
      put(1 - p, 5'h0e, w[0]);
      put(1 - p, 5'h10, w[0]);
      for (int g = 1; g >= 0; g--) begin
        put(p, {4'h5, g[0]}, ~w[0]);
        i_parity_odd = 1'($urandom);
        #1;
        check("box_out", bus_w[p], g ? gen_word(w[0], i_parity_odd) : w[0]);
        check("box_fault_n", fault_n[p], g ? 1'b1 : fault_exp(w[0], i_parity_odd));
        check("box_oe", oe[p], 1'b1);
      end
      put(p, 5'h10, 36'h0_0000_0000);
    end
    // FIFO: fill until refused, then drain back to back past empty.
    for (int i = 0; i < 5; i++) begin
      w[i] = rnd_word();
      put(0, 5'h0c, w[i]);
      #1;
      check("fifo_ready", fifo_ready, i < 4);
    end
    put(0, 5'h10, w[0]);
    check("fifo_valid", fifo_valid, 1'b1);
    for (int i = 0; i < 6; i++) begin
      gen = 1'($urandom);
      put(1, {4'h4, gen}, rnd_word());
      i_parity_odd = 1'($urandom);
      exp_q[i] = (i < 4) ? (gen ? gen_word(w[i], i_parity_odd) : w[i]) : exp_q[3];
      #1;
      if (i > 0) begin
        check("fifo_out", bus_w[1], exp_q[i-1]);
      end
    end
    check("fifo_valid", fifo_valid, 1'b0);
    stop_test();
  end
endmodule
